// ===== src/idr_bitsel.sv
// Bit address decode and single bit insert or extract
`default_nettype none
module idr_bitsel
  import idr_pkg::*;
(
  input wire logic [7:0] bit_addr_in,
  input wire logic [7:0] byte_in,
  input wire logic bit_in,
  output logic [7:0] byte_addr_out,
  output logic bit_out,
  output logic [7:0] byte_out
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [2:0] idx;
  logic [7:0] mask;
  assign idx = bit_addr_in[2:0];
  assign mask = IDR_ONE << idx;
  // High bits only reach SPECIAL_FUNCTION_SPACE bytes ending 0H or 8H
  assign byte_addr_out = bit_addr_in[7] ? {bit_addr_in[7:3], IDR_ZERO3}
                                        : {IDR_BITRAM_HI, bit_addr_in[6:3]};
  assign bit_out = byte_in[idx];
  assign byte_out = bit_in ? (byte_in | mask) : (byte_in & ~mask);
endmodule : idr_bitsel
`default_nettype wire

// ===== src/idr_bytemem.sv
// Byte array with combinational read and clocked write
`default_nettype none
module idr_bytemem #(
  parameter int AW = 8
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // No reset: contents are undefined until written
  logic [7:0] mem_r [0:(1<<AW)-1];

  assign rdata_out = mem_r[raddr_in];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end
endmodule : idr_bytemem
`default_nettype wire

// ===== src/idr_pkg.sv
// Shared types and constants of the internal data memory block
`default_nettype none
package idr_pkg;
  // ----------------------------------------
  // Address space
  // ----------------------------------------
  localparam int IDR_AW = 8;
  localparam int IDR_DEPTH = 256;
  localparam int IDR_SFR_AW = 7;
  localparam logic [7:0] IDR_UPPER_BASE = 8'h80;
  localparam logic [3:0] IDR_BITRAM_HI = 4'h2;
  localparam logic [2:0] IDR_ZERO3 = 3'h0;
  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] IDR_SP_RST = 8'h07;
  localparam logic [7:0] IDR_PSW_RST = 8'h00;
  localparam int IDR_BANK_LO = 3;
  localparam int IDR_BANK_HI = 4;
  localparam logic [7:0] IDR_ONE = 8'h01;
  // ----------------------------------------
  // Request encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    IDR_CMD_BYTE,
    IDR_CMD_BIT,
    IDR_CMD_STACK
  } idr_cmd_t;
  typedef enum logic [1:0] {
    IDR_AM_DIRECT,
    IDR_AM_INDIRECT,
    IDR_AM_BANKREG
  } idr_mode_t;
  typedef enum logic [2:0] {
    IDR_RT_NONE,
    IDR_RT_RAM,
    IDR_RT_SFR,
    IDR_RT_SP,
    IDR_RT_PSW
  } idr_route_t;
  typedef struct packed {
    logic rd;
    logic wr;
    idr_cmd_t cmd;
    idr_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } idr_req_t;
endpackage : idr_pkg
`default_nettype wire

// ===== src/idr_top.sv
// Internal data memory: lower and upper RAM, SPECIAL_FUNCTION_SPACE store, banks, bits, stack
//
// Function
// - Data addresses are 8 bits; 256 byte locations apart from code.
// - Direct access above 7FH goes to the SPECIAL_FUNCTION_SPACE space only.
// - Indirect access above 7FH goes to upper 128 RAM bytes.
// - SPECIAL_FUNCTION_SPACE space and upper RAM are separate stores.
// - SPECIAL_FUNCTION_SPACE bit access only at addresses ending 0H or 8H.
// - Lowest 32 bytes are 4 banks of 8 registers.
// - Status word bits 3 and 4 select the active bank.
// - Bytes 20H-2FH hold bit addresses 00H-7FH, LSB first.
// - Lower half direct or indirect; upper half indirect only.
// - Stack pointer resets to 07H and is writable.
// - Push increments the pointer, then writes.
// - Pop reads, then decrements the pointer.
// - Stack may sit anywhere in 256 bytes; holds return addresses.
`default_nettype none
module idr_top
  import idr_pkg::*;
#(
  // Direct addresses of the two SFRs kept in this block
  parameter logic [7:0] SP_SFR_ADDR = 8'h81,
  parameter logic [7:0] PSW_SFR_ADDR = 8'hd0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire idr_req_t req_in,
  input wire logic wrap_clr_in,
  output logic [7:0] rdata_out,
  output logic [7:0] stack_pointer_out,
  output logic [7:0] program_status_word_out,
  output logic [1:0] bank_out,
  output idr_route_t route_out,
  output logic stack_wrap_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] sp_r;
  logic [7:0] sp_nxt;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] bank_r;
  idr_route_t route_r;
  idr_route_t route_nxt;
  logic wrap_r;
  logic wrap_nxt;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic do_rd;
  logic do_wr;
  logic any_op;
  logic is_byte;
  logic is_bit;
  logic is_stack;
  logic is_direct;
  logic is_indirect;
  logic is_bankreg;
  logic push_op;
  logic pop_op;

  // Read wins if a master ever raises both strobes
  assign do_rd = req_in.rd;
  assign do_wr = req_in.wr & ~req_in.rd;
  assign any_op = do_rd | do_wr;
  assign is_byte = (req_in.cmd == IDR_CMD_BYTE);
  assign is_bit = (req_in.cmd == IDR_CMD_BIT);
  assign is_stack = (req_in.cmd == IDR_CMD_STACK);
  assign is_direct = (req_in.mode == IDR_AM_DIRECT);
  assign is_indirect = (req_in.mode == IDR_AM_INDIRECT);
  assign is_bankreg = (req_in.mode == IDR_AM_BANKREG);
  assign push_op = is_stack & do_wr;
  assign pop_op = is_stack & do_rd;

  // ----------------------------------------
  // Address generation
  // ----------------------------------------
  logic [7:0] bank_addr;
  logic [7:0] byte_addr;
  logic [7:0] bit_byte_addr;
  logic [7:0] sp_inc;
  logic [7:0] sp_dec;
  logic [7:0] stack_addr;
  logic [7:0] tgt_addr;

  // Register number inside a bank of eight
  // Bank from status word bits 4:3
  assign bank_addr = {IDR_ZERO3, bank_r, req_in.addr[2:0]};
  // Full 8-bit address for byte access
  assign byte_addr = is_bankreg ? bank_addr : req_in.addr;
  assign sp_inc = sp_r + IDR_ONE;
  assign sp_dec = sp_r - IDR_ONE;
  assign stack_addr = push_op ? sp_inc : sp_r;
  assign tgt_addr = is_stack ? stack_addr
                  : is_bit ? bit_byte_addr
                  : byte_addr;

  // ----------------------------------------
  // Space routing
  // ----------------------------------------
  logic upper_half;
  logic to_sfr;
  logic to_ram;
  logic hit_sp;
  logic hit_psw;
  logic hit_sfr_mem;

  assign upper_half = (tgt_addr >= IDR_UPPER_BASE);
  // Direct upper addresses go to SPECIAL_FUNCTION_SPACE space
  // Indirect upper addresses go to upper RAM
  // Upper RAM is never reached by direct byte or bit requests; stack requests in direct mode do reach it
  // Stack always addresses RAM, any location
  assign to_sfr = upper_half & ~is_stack & (is_bit | (is_byte & is_direct));
  assign to_ram = ~to_sfr;
  assign hit_sp = to_sfr & (tgt_addr == SP_SFR_ADDR);
  assign hit_psw = to_sfr & (tgt_addr == PSW_SFR_ADDR);
  assign hit_sfr_mem = to_sfr & ~hit_sp & ~hit_psw;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ram_rdata;
  logic [7:0] sfr_rdata;
  logic [7:0] wr_byte;
  logic ram_we;
  logic sfr_we;

  // Upper RAM and SPECIAL_FUNCTION_SPACE bytes live in separate arrays
  assign ram_we = do_wr & to_ram;
  assign sfr_we = do_wr & hit_sfr_mem;

  idr_bytemem #(
    .AW(IDR_AW)
  ) u_ram (
    .clk_in(clk_in),
    .we_in(ram_we),
    .waddr_in(tgt_addr),
    .wdata_in(wr_byte),
    .raddr_in(tgt_addr),
    .rdata_out(ram_rdata)
  );

  idr_bytemem #(
    .AW(IDR_SFR_AW)
  ) u_sfr (
    .clk_in(clk_in),
    .we_in(sfr_we),
    .waddr_in(tgt_addr[IDR_SFR_AW-1:0]),
    .wdata_in(wr_byte),
    .raddr_in(tgt_addr[IDR_SFR_AW-1:0]),
    .rdata_out(sfr_rdata)
  );

  // ----------------------------------------
  // Current byte and bit handling
  // ----------------------------------------
  logic [7:0] sfr_byte;
  logic [7:0] cur_byte;
  logic cur_bit;
  logic [7:0] bit_merged;

  assign sfr_byte = hit_sp ? sp_r
                  : hit_psw ? psw_r
                  : sfr_rdata;
  assign cur_byte = to_sfr ? sfr_byte : ram_rdata;

  // Bit ops reach only bit-addressable bytes
  idr_bitsel u_bitsel (
    .bit_addr_in(req_in.addr),
    .byte_in(cur_byte),
    .bit_in(req_in.wdata[0]),
    .byte_addr_out(bit_byte_addr),
    .bit_out(cur_bit),
    .byte_out(bit_merged)
  );

  // Bit writes are read-modify-write within one cycle
  assign wr_byte = is_bit ? bit_merged : req_in.wdata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic sp_wr;
  logic psw_wr;

  assign sp_wr = do_wr & hit_sp;
  assign psw_wr = do_wr & hit_psw;

  // Push increments pointer with the write
  assign sp_nxt = sp_wr ? wr_byte
                : push_op ? sp_inc
                : pop_op ? sp_dec
                : sp_r;
  assign psw_nxt = psw_wr ? wr_byte : psw_r;
  assign rdata_nxt = is_bit ? {7'h00, cur_bit} : cur_byte;

  assign route_nxt = ~any_op ? IDR_RT_NONE
                   : hit_sp ? IDR_RT_SP
                   : hit_psw ? IDR_RT_PSW
                   : to_sfr ? IDR_RT_SFR
                   : IDR_RT_RAM;

  // Wrap flag: set by a push from FFH or a pop from 00H
  // A set in the clear cycle wins so no wrap is lost
  logic wrap_evt;
  assign wrap_evt = (push_op & (sp_r == 8'hff)) | (pop_op & (sp_r == 8'h00));
  assign wrap_nxt = wrap_evt | (wrap_r & ~wrap_clr_in);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Pointer reset value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sp_r <= IDR_SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Bank copy tracks status word bits 4:3
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      psw_r <= IDR_PSW_RST;
      bank_r <= IDR_PSW_RST[IDR_BANK_HI:IDR_BANK_LO];
    end else begin
      psw_r <= psw_nxt;
      bank_r <= psw_nxt[IDR_BANK_HI:IDR_BANK_LO];
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r <= 8'h00;
    end else if (do_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      route_r <= IDR_RT_NONE;
      wrap_r <= 1'b0;
    end else begin
      route_r <= route_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Return-address byte order is the core's; pointer only counts
  assign rdata_out = rdata_r;
  assign stack_pointer_out = sp_r;
  assign program_status_word_out = psw_r;
  assign bank_out = bank_r;
  assign route_out = route_r;
  assign stack_wrap_out = wrap_r;
endmodule : idr_top
`default_nettype wire

// ===== tb/idr_core_model.sv
// Core execution unit model issuing data memory requests
`default_nettype none
module idr_core_model
  import idr_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output var idr_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_out = '0;
  // One request then idle; read data stands only in the next cycle
  task automatic xfer(input logic r, input logic w, input idr_cmd_t c, input idr_mode_t m,
    input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    req_out <= '{r, w, c, m, a, d};
    @(posedge clk_in);
    req_out <= '0;
    #1 q = rdata_in;
  endtask : xfer
  // return address low pushed first, high popped first
  task automatic call_ret(input logic [15:0] ra, output logic [15:0] got);
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b1, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, ra[7:0]};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b1, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, ra[15:8]};
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b0, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, 8'h00};
    @(posedge clk_in);
    #1 got[15:8] = rdata_in;
    @(posedge clk_in);
    req_out <= '0;
    #1 got[7:0] = rdata_in;
  endtask : call_ret
endmodule : idr_core_model
`default_nettype wire

// ===== tb/idr_top_properties.sv
// Port checks of the data memory block
`default_nettype none
module idr_top_props
  import idr_pkg::*;
#(
  // Must match the status word address of the bound block
  parameter logic [7:0] PSW_ADDR = 8'hd0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire idr_req_t req_in,
  input wire logic wrap_clr_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic [7:0] program_status_word_out,
  input wire logic [1:0] bank_out,
  input wire idr_route_t route_out,
  input wire logic stack_wrap_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_push;
    req_in.wr && !req_in.rd && req_in.cmd == IDR_CMD_STACK;
  endsequence
  sequence s_pop;
    req_in.rd && req_in.cmd == IDR_CMD_STACK;
  endsequence
  sequence s_hi;
    (req_in.rd || req_in.wr) && req_in.cmd == IDR_CMD_BYTE && req_in.addr[7];
  endsequence
  AST_SP_RST: assert property ($rose(nrst_in) |-> stack_pointer_out == 8'h07)
    else $error("stack pointer off after reset");
  AST_PUSH_INC: assert property (s_push |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01)
    else $error("push did not advance pointer");
  AST_POP_DEC: assert property (s_pop |=> stack_pointer_out == $past(stack_pointer_out) - 8'h01)
    else $error("pop did not step pointer back");
  AST_WRAP: assert property (s_push and stack_pointer_out == 8'hff |=> stack_wrap_out)
    else $error("pointer wrap not flagged");
  AST_BANK: assert property (bank_out == program_status_word_out[4:3])
    else $error("bank differs from status bits");
  AST_BANK_WR: assert property (req_in.wr && !req_in.rd && req_in.cmd == IDR_CMD_BYTE
    && req_in.mode == IDR_AM_DIRECT && req_in.addr == PSW_ADDR
    |=> bank_out == $past(req_in.wdata[4:3]))
    else $error("status word write did not switch bank");
  AST_DIR_HI: assert property (s_hi and req_in.mode == IDR_AM_DIRECT |=> route_out != IDR_RT_RAM)
    else $error("direct upper access reached ram");
  AST_IND_HI: assert property (s_hi and req_in.mode == IDR_AM_INDIRECT |=> route_out == IDR_RT_RAM)
    else $error("indirect upper access missed ram");
  AST_POP_DATA: assert property (s_push ##1 s_pop |=> rdata_out == $past(req_in.wdata, 2))
    else $error("pop did not return last push");
endmodule : idr_top_props
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the internal data memory block
`default_nettype none
module testbench
  import idr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wrap_clr_in = 1'b0;
  idr_req_t req;
  logic [7:0] rdata, sp, program_status_word, q;
  logic [1:0] bank;
  idr_route_t route;
  logic wrap;
  logic [15:0] ra;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 clk_in = ~clk_in;
  idr_top #(.SP_SFR_ADDR(8'h81), .PSW_SFR_ADDR(8'hd0)) DUT (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(req), .wrap_clr_in(wrap_clr_in), .rdata_out(rdata), .stack_pointer_out(sp),
    .program_status_word_out(program_status_word), .bank_out(bank), .route_out(route), .stack_wrap_out(wrap));
  idr_core_model core (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wd(input logic [7:0] a, input logic [7:0] d);
    core.xfer(1'b0, 1'b1, IDR_CMD_BYTE, IDR_AM_DIRECT, a, d, q);
  endtask : wd
  task automatic rdd(input logic [7:0] a);
    core.xfer(1'b1, 1'b0, IDR_CMD_BYTE, IDR_AM_DIRECT, a, 8'h00, q);
  endtask : rdd
  task automatic t_split;
    wd(8'h90, 8'ha5);
    core.xfer(1'b0, 1'b1, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'h90, 8'h3c, q);
    rdd(8'h90);
    chk("sfr90", 8'ha5, q);
    chk("route", {5'h0, IDR_RT_SFR}, {5'h0, route});
    core.xfer(1'b1, 1'b0, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'h90, 8'h00, q);
    chk("ram90", 8'h3c, q);
    wd(8'h7f, 8'h5e);
    core.xfer(1'b1, 1'b0, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'h7f, 8'h00, q);
    chk("ram7f", 8'h5e, q);
    core.xfer(1'b0, 1'b1, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'hff, 8'hc3, q);
    core.xfer(1'b1, 1'b0, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'hff, 8'h00, q);
    chk("ramff", 8'hc3, q);
  endtask : t_split
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      wd(8'hd0, 8'(b << 3));
      chk("bank", 8'(b), {6'h0, bank});
      core.xfer(1'b0, 1'b1, IDR_CMD_BYTE, IDR_AM_BANKREG, 8'h07, 8'(8'h10 + b), q);
    end
    for (int b = 0; b < 4; b++) begin
      rdd(8'(b * 8 + 7));
      chk("bankreg", 8'(8'h10 + b), q);
    end
    rdd(8'hd0);
    chk("pswrd", 8'h18, q);
    chk("route", {5'h0, IDR_RT_PSW}, {5'h0, route});
  endtask : t_banks
  task automatic t_bits;
    wd(8'h21, 8'h00);
    wd(8'ha8, 8'h00);
    core.xfer(1'b0, 1'b1, IDR_CMD_BIT, IDR_AM_DIRECT, 8'h0b, 8'h01, q);
    core.xfer(1'b0, 1'b1, IDR_CMD_BIT, IDR_AM_DIRECT, 8'hae, 8'h01, q);
    rdd(8'h21);
    chk("byte21", 8'h08, q);
    rdd(8'ha8);
    chk("sfra8", 8'h40, q);
    core.xfer(1'b1, 1'b0, IDR_CMD_BIT, IDR_AM_DIRECT, 8'h0b, 8'h00, q);
    chk("bit0b", 8'h01, q);
    core.xfer(1'b1, 1'b0, IDR_CMD_BIT, IDR_AM_DIRECT, 8'h0a, 8'h00, q);
    chk("bit0a", 8'h00, q);
    core.xfer(1'b0, 1'b1, IDR_CMD_BIT, IDR_AM_DIRECT, 8'hae, 8'h00, q);
    rdd(8'ha8);
    chk("sfra8clr", 8'h00, q);
  endtask : t_bits
  task automatic t_stack;
    core.call_ret(16'h1234, ra);
    chk("ret", 8'h12, ra[15:8]);
    chk("retlo", 8'h34, ra[7:0]);
    chk("sp", 8'h07, sp);
    rdd(8'h08);
    chk("stk08", 8'h34, q);
    wd(8'h81, 8'hff);
    core.xfer(1'b0, 1'b1, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, 8'h6d, q);
    chk("spwrap", 8'h00, sp);
    rdd(8'h00);
    chk("stk00", 8'h6d, q);
    chk("wrap", 8'h01, {7'h00, wrap});
    // Clear held high across a second wrap: the set must win
    @(posedge clk_in);
    wrap_clr_in <= 1'b1;
    wd(8'h81, 8'hff);
    core.xfer(1'b0, 1'b1, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, 8'h77, q);
    chk("wrapset", 8'h01, {7'h00, wrap});
    @(posedge clk_in);
    wrap_clr_in <= 1'b0;
    #1;
    chk("wrapclr", 8'h00, {7'h00, wrap});
    wd(8'h81, 8'hc0);
    core.xfer(1'b0, 1'b1, IDR_CMD_STACK, IDR_AM_DIRECT, 8'h00, 8'h5a, q);
    core.xfer(1'b1, 1'b0, IDR_CMD_BYTE, IDR_AM_INDIRECT, 8'hc1, 8'h00, q);
    chk("stkc1", 8'h5a, q);
  endtask : t_stack
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // Run is about 100 cycles; the ceiling leaves wide margin
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("sp", 8'h07, sp);
    chk("psw", 8'h00, program_status_word);
    t_split();
    t_banks();
    t_bits();
    t_stack();
    wrap_up();
  end
endmodule : testbench
bind idr_top idr_top_props #(.PSW_ADDR(PSW_SFR_ADDR)) u_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .req_in(req_in),
  .wrap_clr_in(wrap_clr_in), .rdata_out(rdata_out), .stack_pointer_out(stack_pointer_out),
  .program_status_word_out(program_status_word_out), .bank_out(bank_out),
  .route_out(route_out), .stack_wrap_out(stack_wrap_out));
`default_nettype wire
